// ===== hdl/btbc_core.sv
// Device-side burst engine: column commands, burst terminate, write
// masking, 4-beat commit, precharge and auto close, plus a Wishbone slave.
// Assumes link pins are asynchronous to clk_sys and the link clock is
// well below half the clk_sys rate.
`timescale 1ns/10ps
`include "btbc_consts.svh"

module btbc_core
    import btbc_pkg::*;
#(
    parameter int DQ_W     = 32,
    parameter int COL_BITS = 5,
    parameter int LAT_MAX  = `BTBC_LAT_MAX,
    parameter int RTP_CK   = `BTBC_RTP_CK,
    parameter int WR_CK    = `BTBC_WR_CK
) (
    // System
    input  wire logic              clk_sys,
    input  wire logic              srst,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Command and address pins
    input  wire logic              ck_i,
    input  wire logic              cs_n_i,
    input  wire logic [9:0]        ca_i,
    // Data pins
    input  wire logic [DQ_W/8-1:0] write_byte_mask_i,
    input  wire logic [DQ_W-1:0]   dq_i,
    output logic      [DQ_W-1:0]   dq_o,
    output logic                   dq_oe_n,
    input  wire logic              dqs_i,
    output logic                   dqs_o,
    output logic                   dqs_oe_n
);

    localparam int BYTES = DQ_W / 8;
    localparam int AW    = 3 + COL_BITS;
    localparam int SW    = 1 + 1 + 10 + BYTES + DQ_W + 1;
    localparam int PF    = `BTBC_PREFETCH;

    if (DQ_W % 8 != 0 || DQ_W < 8 || COL_BITS < 4 ||
        COL_BITS > `BTBC_COL_W || LAT_MAX < 1 || LAT_MAX > 15 ||
        RTP_CK < 1 || WR_CK < 1) begin : g_bad_param
        $error("btbc_core: unsupported parameter values");
    end

    // Pin synchronisation and edge detection
    logic [SW-1:0]    pin_s;
    logic             ck_s, cs_n_s, dqs_s;
    logic [9:0]       ca_s;
    logic [BYTES-1:0] dm_s;
    logic [DQ_W-1:0]  dq_s;
    logic             ck_prev_q, dqs_prev_q;
    logic             ck_rise, ck_fall, ck_edge, dqs_edge;

    btbc_sync #(.WIDTH(SW)) u_sync (
        .clk_sys (clk_sys),
        .srst    (srst),
        .d_i     ({ck_i, cs_n_i, ca_i, write_byte_mask_i, dq_i, dqs_i}),
        .q_o     (pin_s)
    );

    assign {ck_s, cs_n_s, ca_s, dm_s, dq_s, dqs_s} = pin_s;
    assign ck_rise  = ck_s & ~ck_prev_q;
    assign ck_fall  = ~ck_s & ck_prev_q;
    assign ck_edge  = ck_rise | ck_fall;
    assign dqs_edge = dqs_s ^ dqs_prev_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ck_prev_q  <= 1'b0;
            dqs_prev_q <= 1'b0;
        end else begin
            ck_prev_q  <= ck_s;
            dqs_prev_q <= dqs_s;
        end
    end

    // Rising-edge half of the command word
    logic       cs_n_r_q;
    logic [9:0] ca_r_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cs_n_r_q <= 1'b1;
            ca_r_q   <= 10'h000;
        end else if (ck_rise) begin
            cs_n_r_q <= cs_n_s;
            ca_r_q   <= ca_s;
        end
    end

    // Configuration and derived settings
    logic [`BTBC_CFG_W-1:0] cfg_q;
    logic [4:0]             bl_beats;
    int                     rl_i, wl_i;

    function automatic int lat_of(input logic [3:0] f);
        if (f == 4'h0) begin
            return 1;
        end else if (int'(f) > LAT_MAX) begin
            return LAT_MAX;
        end
        return int'(f);
    endfunction

    always_comb begin
        case (cfg_q[`BTBC_CFG_BL_MSB:`BTBC_CFG_BL_LSB])
            `BTBC_BL4_CODE: bl_beats = `BTBC_BL4_BEATS;
            `BTBC_BL8_CODE: bl_beats = `BTBC_BL8_BEATS;
            default:        bl_beats = `BTBC_BL16_BEATS;
        endcase
        rl_i = lat_of(cfg_q[`BTBC_CFG_RL_MSB:`BTBC_CFG_RL_LSB]);
        wl_i = lat_of(cfg_q[`BTBC_CFG_WL_MSB:`BTBC_CFG_WL_LSB]);
    end

    // Command decode at the falling edge, once CA0f is known
    logic      sel_cmd, is_rw, is_bst, is_pre;
    btbc_cmd_t cmd;
    logic      pre_fire, pre_all;
    logic [2:0] pre_bank;

    always_comb begin
        sel_cmd = ck_fall & ~cs_n_r_q;
        is_rw   = sel_cmd &&
                  ((ca_r_q[3:0] & `BTBC_CA_RW_MASK) == `BTBC_CA_RW);
        is_bst  = sel_cmd && (ca_r_q[3:0] == `BTBC_CA_BST);
        is_pre  = sel_cmd && (ca_r_q[3:0] == `BTBC_CA_PRE);
        cmd.kind = BTBC_K_NONE;
        if (is_rw) begin
            cmd.kind = ca_r_q[`BTBC_CA_RD_BIT] ? BTBC_K_RD : BTBC_K_WR;
        end else if (is_bst) begin
            cmd.kind = BTBC_K_BST;
        end
        cmd.bank = ca_r_q[9:7];
        cmd.col  = {ca_s[9:1], ca_r_q[6:5]};
        cmd.ap   = ca_s[0];
        pre_fire = is_pre;
        pre_all  = ca_r_q[4];
        pre_bank = cfg_q[`BTBC_CFG_EIGHT] ? ca_r_q[9:7]
                                          : {1'b0, ca_r_q[8:7]};
    end

    // Latency pipeline, shifted once per link cycle
    btbc_cmd_t pipe_q [LAT_MAX];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < LAT_MAX; i++) begin
                pipe_q[i] <= '0;
            end
        end else if (ck_fall) begin
            pipe_q[0] <= cmd;
            for (int i = 1; i < LAT_MAX; i++) begin
                pipe_q[i] <= pipe_q[i-1];
            end
        end
    end

    // Effective length bookkeeping
    logic [4:0] since_q;
    logic [5:0] last_eff_q;
    logic       bst_used_q;
    logic       bst_fire;

    // A second terminate after the first is ignored
    assign bst_fire = is_bst & ~bst_used_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            since_q    <= 5'h00;
            last_eff_q <= 6'h00;
            bst_used_q <= 1'b0;
        end else begin
            if (is_rw) begin
                since_q    <= 5'h00;
                bst_used_q <= 1'b0;
                if (cmd.kind == BTBC_K_WR && since_q < bl_beats[4:1]) begin
                    last_eff_q <= {since_q, 1'b0};
                end
            end else if (ck_rise && since_q != 5'h1F) begin
                since_q <= since_q + 5'h01;
            end
            if (bst_fire) begin
                last_eff_q <= {since_q, 1'b0};
                bst_used_q <= 1'b1;
            end
        end
    end

    // Burst engine on delayed commands
    btbc_burst_t         st_q;
    logic [4:0]          beat_q, lim_q;
    logic [2:0]          bbank_q;
    logic [COL_BITS-1:0] bcol_q;
    btbc_cmd_t           rd_tap, wr_tap;
    logic                rd_arr, wr_arr, bst_rd, bst_wr, wbeat;
    logic [4:0]          wb_idx;

    always_comb begin
        rd_tap = pipe_q[rl_i-1];
        wr_tap = pipe_q[wl_i-1];
        rd_arr = ck_rise && rd_tap.kind == BTBC_K_RD;
        wr_arr = ck_rise && wr_tap.kind == BTBC_K_WR;
        bst_rd = ck_rise && st_q == BTBC_B_RD &&
                 rd_tap.kind == BTBC_K_BST;
        bst_wr = ck_rise && st_q == BTBC_B_WR &&
                 wr_tap.kind == BTBC_K_BST;
        wbeat  = dqs_edge && !bst_wr && (wr_arr || st_q == BTBC_B_WR);
        wb_idx = wr_arr ? 5'h00 : beat_q;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_q    <= BTBC_B_IDLE;
            beat_q  <= 5'h00;
            lim_q   <= 5'h00;
            bbank_q <= 3'h0;
            bcol_q  <= '0;
        end else if (wr_arr) begin
            // A newer write takes over the running one
            st_q    <= BTBC_B_WR;
            beat_q  <= wbeat ? 5'h01 : 5'h00;
            lim_q   <= bl_beats;
            bbank_q <= wr_tap.bank;
            bcol_q  <= wr_tap.col[COL_BITS-1:0];
        end else if (rd_arr) begin
            st_q    <= BTBC_B_RD;
            beat_q  <= 5'h01;
            lim_q   <= bl_beats;
            bbank_q <= rd_tap.bank;
            bcol_q  <= rd_tap.col[COL_BITS-1:0];
        end else begin
            case (st_q)
                BTBC_B_WR: begin
                    if (bst_wr) begin
                        st_q <= BTBC_B_IDLE;
                    end else if (wbeat) begin
                        beat_q <= beat_q + 5'h01;
                        if (beat_q + 5'h01 == lim_q) begin
                            st_q <= BTBC_B_IDLE;
                        end
                    end
                end
                BTBC_B_RD: begin
                    if (bst_rd) begin
                        st_q <= BTBC_B_IDLE;
                    end else if (ck_edge) begin
                        if (beat_q == lim_q) begin
                            st_q <= BTBC_B_IDLE;
                        end else begin
                            beat_q <= beat_q + 5'h01;
                        end
                    end
                end
                default: begin
                    st_q <= BTBC_B_IDLE;
                end
            endcase
        end
    end

    // Array and read path
    logic [DQ_W-1:0]     mem_q [1 << AW];
    logic                rd_drive;
    logic [COL_BITS-1:0] rd_col;

    always_comb begin
        rd_drive = rd_arr || (st_q == BTBC_B_RD && ck_edge && !bst_rd &&
                              beat_q != lim_q);
        rd_col   = rd_arr ? rd_tap.col[COL_BITS-1:0]
                          : bcol_q + COL_BITS'(beat_q);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dq_o     <= '0;
            dq_oe_n  <= 1'b1;
            dqs_o    <= 1'b0;
            dqs_oe_n <= 1'b1;
        end else if (ck_edge) begin
            if (rd_drive) begin
                dq_o     <= mem_q[{rd_arr ? rd_tap.bank : bbank_q, rd_col}];
                dq_oe_n  <= 1'b0;
                dqs_o    <= ck_s;
                dqs_oe_n <= 1'b0;
            end else begin
                dq_oe_n  <= 1'b1;
                dqs_oe_n <= 1'b1;
                dqs_o    <= 1'b0;
            end
        end
    end

    // Prefetch group: beats gather, then commit as one group
    logic [DQ_W-1:0]  grp_dat_q [PF];
    logic [BYTES-1:0] grp_msk_q [PF];
    logic [1:0]       grp_cnt_q;
    logic [AW-1:0]    grp_adr_q;
    logic             commit_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            grp_cnt_q <= 2'h0;
            grp_adr_q <= '0;
            commit_q  <= 1'b0;
            for (int i = 0; i < PF; i++) begin
                grp_dat_q[i] <= '0;
                grp_msk_q[i] <= '0;
            end
        end else begin
            commit_q <= wbeat && grp_cnt_q == 2'h3;
            if (wbeat) begin
                grp_dat_q[grp_cnt_q] <= dq_s;
                grp_msk_q[grp_cnt_q] <= dm_s;
                grp_cnt_q            <= grp_cnt_q + 2'h1;
                if (wr_arr || grp_cnt_q == 2'h0) begin
                    grp_cnt_q <= 2'h1;
                    grp_dat_q[0] <= dq_s;
                    grp_msk_q[0] <= dm_s;
                    grp_adr_q <= wr_arr
                        ? {wr_tap.bank, wr_tap.col[COL_BITS-1:0]}
                        : {bbank_q, bcol_q + COL_BITS'(wb_idx)};
                end
            end else if (wr_arr) begin
                grp_cnt_q <= 2'h0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (commit_q) begin
            for (int i = 0; i < PF; i++) begin
                for (int b = 0; b < BYTES; b++) begin
                    if (!grp_msk_q[i][b]) begin
                        mem_q[{grp_adr_q[AW-1:COL_BITS],
                               grp_adr_q[COL_BITS-1:0] + COL_BITS'(i)}]
                            [b*8 +: 8] <= grp_dat_q[i][b*8 +: 8];
                    end
                end
            end
        end
    end

    // Auto close countdown in link cycles
    logic       ac_vld_q;
    logic [5:0] ac_cnt_q;
    logic [2:0] ac_bank_q;
    logic [5:0] ac_rd_cnt, ac_wr_cnt;
    logic       ac_fire;

    always_comb begin
        ac_rd_cnt = (RTP_CK > 2) ? 6'({1'b0, bl_beats[4:1]} + 6'(RTP_CK - 2))
                                 : {2'b00, bl_beats[4:1]};
        ac_wr_cnt = 6'(wl_i + 1 + WR_CK) + {2'b00, bl_beats[4:1]};
        ac_fire   = ac_vld_q && ck_rise && ac_cnt_q == 6'h01;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ac_vld_q  <= 1'b0;
            ac_cnt_q  <= 6'h00;
            ac_bank_q <= 3'h0;
        end else if (is_rw && cmd.ap) begin
            ac_vld_q  <= 1'b1;
            ac_bank_q <= cmd.bank;
            ac_cnt_q  <= (cmd.kind == BTBC_K_RD) ? ac_rd_cnt : ac_wr_cnt;
        end else if (ac_vld_q && ck_rise) begin
            ac_cnt_q <= ac_cnt_q - 6'h01;
            if (ac_cnt_q == 6'h01) begin
                ac_vld_q <= 1'b0;
            end
        end
    end

    // Bank open state: software set stands in for activation and wins
    logic [7:0] bank_open_q, bank_set, bank_clr;
    logic       wb_req;

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always_comb begin
        bank_set = (wb_req && wb_we_i && wb_adr_i == `BTBC_ADR_BANK &&
                    wb_sel_i[0]) ? wb_dat_i[7:0] : 8'h00;
        bank_clr = 8'h00;
        if (pre_fire) begin
            bank_clr = pre_all ? 8'hFF : (8'h01 << pre_bank);
        end
        if (ac_fire) begin
            bank_clr = bank_clr | (8'h01 << ac_bank_q);
        end
    end

    // Without auto close a bank stays open until precharge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bank_open_q <= 8'h00;
        end else begin
            bank_open_q <= (bank_open_q & ~bank_clr) | bank_set;
        end
    end

    // Wishbone register slave, one wait state
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_q    <= `BTBC_CFG_RST;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && wb_we_i && wb_adr_i == `BTBC_ADR_CFG) begin
                if (wb_sel_i[0]) begin
                    cfg_q[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    cfg_q[12:8] <= wb_dat_i[12:8];
                end
            end
            if (wb_req) begin
                if (wb_adr_i == `BTBC_ADR_CFG) begin
                    wb_dat_o <= {19'h00000, cfg_q};
                end else if (wb_adr_i == `BTBC_ADR_BANK) begin
                    wb_dat_o <= {24'h000000, bank_open_q};
                end else if (wb_adr_i == `BTBC_ADR_STAT) begin
                    wb_dat_o <= {22'h000000, st_q != BTBC_B_IDLE,
                                 bst_used_q, 2'h0, last_eff_q};
                end else begin
                    wb_dat_o <= 32'h0000_0000;
                end
            end
        end
    end

    // Checks
    chk_ack_pulse: assert property (@(posedge clk_sys) disable iff (srst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_time: assert property (@(posedge clk_sys) disable iff (srst)
        wb_req |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    chk_pre_one: assert property (@(posedge clk_sys) disable iff (srst)
        pre_fire && !pre_all && bank_set == 8'h00 |=>
        !bank_open_q[$past(pre_bank)])
        else $error("single bank precharge left bank open");
    chk_pre_all: assert property (@(posedge clk_sys) disable iff (srst)
        pre_fire && pre_all && bank_set == 8'h00 |=> bank_open_q == 8'h00)
        else $error("all bank precharge left a bank open");
    chk_bst_wr_stop: assert property (@(posedge clk_sys) disable iff (srst)
        bst_wr ##1 !wr_arr [*2] |-> st_q != BTBC_B_WR && !wbeat)
        else $error("write data accepted after terminate");
    chk_bst_rd_stop: assert property (@(posedge clk_sys) disable iff (srst)
        bst_rd && !wr_arr |=> st_q == BTBC_B_IDLE)
        else $error("read burst continued after terminate");
    chk_eff_len: assert property (@(posedge clk_sys) disable iff (srst)
        bst_fire |=> last_eff_q == {$past(since_q), 1'b0})
        else $error("effective length not twice the cycle count");
    chk_commit_group: assert property (@(posedge clk_sys) disable iff (srst)
        commit_q |-> $past(wbeat) && $past(grp_cnt_q) == 2'h3)
        else $error("commit without a full prefetch group");
    chk_auto_close: assert property (@(posedge clk_sys) disable iff (srst)
        ac_fire && bank_set == 8'h00 |=> !bank_open_q[$past(ac_bank_q)])
        else $error("auto close did not close the bank");

    cov_bst_wr: cover property (@(posedge clk_sys) disable iff (srst)
        bst_wr);
    cov_bst_rd: cover property (@(posedge clk_sys) disable iff (srst)
        bst_rd);
    cov_wr_intr: cover property (@(posedge clk_sys) disable iff (srst)
        wr_arr && st_q == BTBC_B_WR);
    cov_commit: cover property (@(posedge clk_sys) disable iff (srst)
        commit_q && grp_msk_q[1] != '0);

endmodule // btbc_core

// ===== hdl/btbc_consts.svh
// Offsets, field positions, reset values and counts of the burst block.
// Included by the package and the core; holds definitions only.
`ifndef BTBC_CONSTS_SVH
`define BTBC_CONSTS_SVH

// Wishbone byte offsets
`define BTBC_ADR_CFG      4'h0
`define BTBC_ADR_BANK     4'h4
`define BTBC_ADR_STAT     4'h8

// Configuration fields
`define BTBC_CFG_W        13
`define BTBC_CFG_BL_LSB   0
`define BTBC_CFG_BL_MSB   1
`define BTBC_CFG_RL_LSB   4
`define BTBC_CFG_RL_MSB   7
`define BTBC_CFG_WL_LSB   8
`define BTBC_CFG_WL_MSB   11
`define BTBC_CFG_EIGHT    12
`define BTBC_CFG_RST      13'h1131

// Burst length codes and beats
`define BTBC_BL4_CODE     2'h0
`define BTBC_BL8_CODE     2'h1
`define BTBC_BL4_BEATS    5'h04
`define BTBC_BL8_BEATS    5'h08
`define BTBC_BL16_BEATS   5'h10

// Command encodings on CA[3:0] at the rising edge
`define BTBC_CA_RW_MASK   4'h3
`define BTBC_CA_RW        4'h1
`define BTBC_CA_BST       4'h3
`define BTBC_CA_PRE       4'hB
`define BTBC_CA_RD_BIT    2

// Command field width, prefetch size, timing counts in link cycles
`define BTBC_COL_W        11
`define BTBC_PREFETCH     4
`define BTBC_LAT_MAX      8
`define BTBC_RTP_CK       2
`define BTBC_WR_CK        3

`endif

// ===== hdl/btbc_pkg.sv
// Types shared by the burst truncate and bank close block.
// Assumes btbc_consts.svh is on the include path.
`include "btbc_consts.svh"

package btbc_pkg;

    typedef enum logic [1:0] {
        BTBC_K_NONE,
        BTBC_K_RD,
        BTBC_K_WR,
        BTBC_K_BST
    } btbc_kind_t;

    typedef enum logic [1:0] {
        BTBC_B_IDLE,
        BTBC_B_RD,
        BTBC_B_WR
    } btbc_burst_t;

    typedef struct packed {
        btbc_kind_t             kind;
        logic [2:0]             bank;
        logic [`BTBC_COL_W-1:0] col;
        logic                   ap;
    } btbc_cmd_t;

endpackage : btbc_pkg

// ===== hdl/btbc_sync.sv
// Two-stage synchroniser for a bundle of pin levels.
// Assumes every bit is a level from outside the clk_sys domain.
`timescale 1ns/10ps

module btbc_sync #(
    parameter int WIDTH = 1
) (
    // System
    input  wire logic             clk_sys,
    input  wire logic             srst,
    // Levels
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_q;

    if (WIDTH < 1) begin : g_bad_width
        $error("btbc_sync: WIDTH must be at least 1");
    end

    // First stage feeds only the second
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end

endmodule // btbc_sync

// ===== tb/btbc_ctl.sv
// Controller model: free link clock, commands and write beats.
// Assumes clk_sys at 200 MHz; one link cycle is 16 system cycles.
`timescale 1ns/10ps

module btbc_ctl (
    // System
    input  wire logic clk_sys,
    // Link pins
    output logic        ck,
    output logic        cs_n = 1'b1,
    output logic [9:0]  ca = 10'h3FF,
    output logic        dqs = 1'b0,
    output logic [31:0] dq = 32'h0,
    output logic [3:0]  mask = 4'h0
);
    logic [3:0] ph = 4'h0;
    int         beats = 0;

    assign ck = ~ph[3];

    always @(posedge clk_sys) begin
        ph <= ph + 4'h1;
        if (beats > 0 && ph[2:0] == 3'h2) begin
            dqs <= ~dqs;
            dq <= $urandom;
            mask <= 4'($urandom);
            beats <= beats - 1;
        end
    end

    // CA set well ahead of each edge: the device sees it two cycles late
    task automatic cmd(input logic [9:0] r, input logic [9:0] f, input int n);
        @(posedge clk_sys);
        while (ph != 4'hB) @(posedge clk_sys);
        cs_n <= 1'b0;
        ca <= r;
        @(posedge clk_sys);
        while (ph != 4'h3) @(posedge clk_sys);
        ca <= f;
        @(posedge clk_sys);
        while (ph != 4'hB) @(posedge clk_sys);
        cs_n <= 1'b1;
        ca <= ~f;
        beats <= n;
    endtask
endmodule // btbc_ctl

// ===== tb/burst_truncate_and_bank_close_tb.sv
// Bench: registers, precharge decode, truncation, interrupt, auto close.
// Assumes the controller model drives every link pin.
`timescale 1ns/10ps

module burst_truncate_and_bank_close_tb;
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, q, dq;
    logic        ack, ck, cs_n, dqs, dq_oe_n, dqs_oe_n;
    logic [9:0]  ca;
    logic [3:0]  mask, b;
    int          error_cnt = 0;
    int          checked = 0;
    int          cyc = 0;
    int          n;
    logic [9:0]  c1 [3] = '{10'h081, 10'h081, 10'h085};
    logic [9:0]  c2 [3] = '{10'h003, 10'h081, 10'h003};

    btbc_ctl ctl (.clk_sys(clk_sys), .ck(ck), .cs_n(cs_n), .ca(ca),
        .dqs(dqs), .dq(dq), .mask(mask));
    btbc_core dut (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(stb),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ck_i(ck),
        .cs_n_i(cs_n), .ca_i(ca), .write_byte_mask_i(mask), .dq_i(dq),
        .dq_o(), .dq_oe_n(dq_oe_n), .dqs_i(dqs), .dqs_o(),
        .dqs_oe_n(dqs_oe_n));

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    function automatic logic [7:0] pre_exp(logic [3:0] s, logic e);
        if (s[3])
            return 8'h00;
        return ~(8'h01 << (e ? s[2:0] : {1'b0, s[1:0]}));
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wb(input logic w, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] r);
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_sys);
        while (ack !== 1'b1) @(posedge clk_sys);
        r = rdat;
        stb <= 1'b0;
        @(posedge clk_sys);
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        void'($urandom(12));
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        wb(1'b0, 4'h0, 32'h0, q);
        check(q, 32'h1131);
        wb(1'b0, 4'hC, 32'h0, q);
        check(q, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            b = 4'($urandom);
            wb(1'b1, 4'h0, {19'h0, i[0], 12'h131}, q);
            wb(1'b1, 4'h4, 32'hFF, q);
            ctl.cmd({b[2:0], 2'b00, b[3], 4'hB}, 10'h0, 0);
            repeat (16) @(posedge clk_sys);
            wb(1'b0, 4'h4, 32'h0, q);
            check(q, {24'h0, pre_exp(b, i[0])});
        end
        $display("test precharge done");
        // Second command two link cycles on: even spacing, inside BL/2-1
        for (int k = 0; k < 3; k++) begin
            ctl.cmd(c1[k], 10'h0, k == 2 ? 0 : 8);
            ctl.cmd(c2[k], 10'h0, k == 1 ? 8 : 0);
            n = 0;
            repeat (200) begin
                @(posedge clk_sys);
                n += int'(dq_oe_n === 1'b0 && dqs_oe_n === 1'b0);
            end
            check(32'((n + 4) >> 3), 32'(k == 2 ? 2 * 2 : 0));
            wb(1'b0, 4'h8, 32'h0, q);
            check({23'h0, q[8:0]},
                {23'h0, c2[k] == 10'h003, 2'b00, 6'(2 * 2)});
        end
        $display("test truncate done");
        // Reopen every bank so only the auto close can clear one
        wb(1'b1, 4'h4, 32'hFF, q);
        ctl.cmd(10'h101, 10'h001, 8);
        repeat (300) @(posedge clk_sys);
        wb(1'b0, 4'h4, 32'h0, q);
        check(q, 32'hFB);
        $display("test auto close done");
        close_out();
    end
endmodule // burst_truncate_and_bank_close_tb
